// *** inc/addr_stack_defines.svh ***
`ifndef ADDR_STACK_DEFINES_SVH
`define ADDR_STACK_DEFINES_SVH
`define STACK_DEPTH 4
`define OFS_CTRL_A 8'h0A
`define OFS_PREV_ADDR_TWO 8'h4E
`define OFS_HIST_SECOND_WORD 8'h4F
`define BANK_SELECT_POS 4
`define STACK_RESET_VALUE 8'h00
`endif

// *** inc/addr_stack_pkg.sv ***
package addr_stack_pkg;
  typedef logic [7:0] addr_byte_t;
  typedef struct packed {
    logic ale;
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } bus_strobes_t;
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_READ,
    PH_WRITE
  } bus_phase_t;
endpackage : addr_stack_pkg

// *** verilog/sync_stage.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser; first stage feeds only the second
// Reset value should match the idle pin levels, so no false edge follows
module sync_stage #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : sync_stage

// *** verilog/addr_history_stack.sv ***
`timescale 1ns/1ps
`include "addr_stack_defines.svh"

// Functional notes
// - Capture muxed address on latch strobe fall
// - Each capture pushes stack, older entries shift
// - Four entries; oldest dropped on push
// - Stack readable at extended offsets 4Eh, 4Fh
// - 4Eh returns address two pushes earlier
// - Capturing 4Eh shifts 0Ah to previous slot
// - Stack reachable only with bank select set
module addr_history_stack
  import addr_stack_pkg::*;
#(
  parameter int DEPTH = `STACK_DEPTH
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ale_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] ad_i,
  output logic [7:0] ad_o,
  output logic ad_oe_n_o,
  output logic bank_select_bit_o
);
  // The read mux picks fixed slots, so only the documented depth works
  if (DEPTH != `STACK_DEPTH) begin : g_bad_depth
    $error("Stack depth must be four");
  end

  // Strobes and lines come from pins, so they are synchronised first
  bus_strobes_t strb_raw;
  bus_strobes_t strb_s;
  addr_byte_t ad_s;
  assign strb_raw = '{ale: ale_i, cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i};

  // Synchroniser resets to the idle levels (strobes high, latch low) so
  // the edge detectors see no false edge when reset lets go
  sync_stage #(
    .WIDTH(12),
    .RESET_VAL(12'h700)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({strb_raw, ad_i}),
    .sync_o({strb_s, ad_s})
  );

  logic ale_prev_q, ale_prev_d;
  logic rd_prev_q, rd_prev_d;
  logic wr_prev_q, wr_prev_d;
  addr_byte_t stack_q [DEPTH];
  addr_byte_t stack_d [DEPTH];
  logic bank_q, bank_d;
  addr_byte_t ad_out_q, ad_out_d;
  logic oe_n_q, oe_n_d;
  bus_phase_t phase_q, phase_d;
  logic ale_fall, rd_fall, wr_rise, wr_ok, stk_hit;

  // Address stays on the lines a full sync delay past the strobe,
  // so the synchronised copy still holds it at the detected edge.
  // Limitation: a strobe level held under one clock can be missed
  // entirely; the host keeps each level four clocks or more
  assign ale_fall = ale_prev_q && !strb_s.ale;
  assign rd_fall = rd_prev_q && !strb_s.rd_n && !strb_s.cs_n;
  assign wr_rise = !wr_prev_q && strb_s.wr_n;
  assign wr_ok = !strb_s.cs_n && (phase_q == PH_WRITE);
  // Only the two stack slots are served here; the rest of the bank is
  // decoded elsewhere, so any other address leaves the lines released
  assign stk_hit = bank_q && (stack_q[0] == `OFS_PREV_ADDR_TWO ||
                              stack_q[0] == `OFS_HIST_SECOND_WORD);

  always_comb begin
    ale_prev_d = strb_s.ale;
    rd_prev_d = strb_s.rd_n;
    wr_prev_d = strb_s.wr_n;
    stack_d = stack_q;
    bank_d = bank_q;
    ad_out_d = ad_out_q;
    oe_n_d = oe_n_q;
    phase_d = phase_q;
    if (ale_fall) begin
      stack_d[0] = ad_s;
      for (int i = 1; i < DEPTH; i++) begin
        stack_d[i] = stack_q[i-1];
      end
      phase_d = PH_IDLE;
    end
    // Write phase must be seen first, so a stray write strobe rise is
    // never taken as a write
    if (!strb_s.wr_n && !strb_s.cs_n) begin
      phase_d = PH_WRITE;
    end
    if (wr_rise && wr_ok) begin
      // Only the bank bit of control A is kept here; stack slots ignore
      // writes entirely
      if (stack_q[0] == `OFS_CTRL_A) begin
        bank_d = ad_s[`BANK_SELECT_POS];
      end
      phase_d = PH_IDLE;
    end
    if (rd_fall) begin
      phase_d = PH_READ;
      if (stk_hit) begin
        oe_n_d = 1'b0;
        // 4Eh shows the slot two pushes back, 4Fh the next older one
        ad_out_d = (stack_q[0] == `OFS_PREV_ADDR_TWO) ?
                   stack_q[2] : stack_q[3];
      end
    end
    if (strb_s.rd_n || strb_s.cs_n) begin
      oe_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ale_prev_q <= 1'b0;
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      for (int i = 0; i < DEPTH; i++) begin
        stack_q[i] <= `STACK_RESET_VALUE;
      end
      bank_q <= 1'b0;
      ad_out_q <= 8'h00;
      oe_n_q <= 1'b1;
      phase_q <= PH_IDLE;
    end else begin
      ale_prev_q <= ale_prev_d;
      rd_prev_q <= rd_prev_d;
      wr_prev_q <= wr_prev_d;
      stack_q <= stack_d;
      bank_q <= bank_d;
      ad_out_q <= ad_out_d;
      oe_n_q <= oe_n_d;
      phase_q <= phase_d;
    end
  end

  assign ad_o = ad_out_q;
  assign ad_oe_n_o = oe_n_q;
  assign bank_select_bit_o = bank_q;

  chk_push_captures: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ale_fall |=> stack_q[0] == $past(ad_s))
    else $error("Captured address not at stack top");
  chk_push_shift: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ale_fall |=> stack_q[1] == $past(stack_q[0]))
    else $error("Stack did not shift on push");
  chk_oldest_drop: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ale_fall |=> stack_q[3] == $past(stack_q[2]))
    else $error("Deepest entry not replaced");
  chk_stack_read: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    rd_fall && stk_hit && stack_q[0] == 8'h4E |=>
    !ad_oe_n_o && ad_o == $past(stack_q[2]))
    else $error("4Eh read did not return two-back address");
  chk_bank_gate: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    rd_fall && !bank_q |=> ad_oe_n_o)
    else $error("Stack driven with bank deselected");
  chk_write_ignored: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !ale_fall |=> stack_q[2] == $past(stack_q[2]))
    else $error("Stack changed without push");
  chk_bank_write: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    wr_rise && wr_ok && stack_q[0] == 8'h0A |=> bank_q == $past(ad_s[4]))
    else $error("Bank select not updated");
  chk_fourth_read: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    rd_fall && stk_hit && stack_q[0] == 8'h4F |=> ad_o == $past(stack_q[3]))
    else $error("4Fh read wrong");
  chk_recover_order: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ale_fall && ad_s == 8'h4E && stack_q[0] == 8'h0A |=>
    stack_q[1] == 8'h0A)
    else $error("0Ah not in previous slot");
  cov_push: cover property (@(posedge clk_i) disable iff (!resetn_i)
    ale_fall);
  cov_bank_on: cover property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(bank_q));
  chk_shift_middle: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ale_fall |=> stack_q[2] == $past(stack_q[1]))
    else $error("Middle entry did not shift on push");
  chk_write_no_push: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    wr_rise && wr_ok && !ale_fall |=>
    stack_q[0] == $past(stack_q[0]) && stack_q[1] == $past(stack_q[1]))
    else $error("Write altered the address stack");
  chk_oe_release: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    strb_s.rd_n || strb_s.cs_n |=> ad_oe_n_o)
    else $error("Lines still driven after read ended");
  chk_bank_steady: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !(wr_rise && wr_ok) |=> bank_q == $past(bank_q))
    else $error("Bank select moved without a write");
  chk_other_addr: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    rd_fall && stack_q[0] != 8'h4E && stack_q[0] != 8'h4F |=> ad_oe_n_o)
    else $error("Lines driven for a non-stack register");
  chk_drive_needs_bank: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    $fell(ad_oe_n_o) |-> $past(bank_q))
    else $error("Lines driven while bank deselected");

  // Scenarios the bench is expected to reach
  cov_stack_read: cover property (@(posedge clk_i) disable iff (!resetn_i)
    rd_fall && stk_hit);
  cov_stack_write: cover property (@(posedge clk_i) disable iff (!resetn_i)
    wr_rise && wr_ok && stk_hit);
  cov_fourth_read: cover property (@(posedge clk_i) disable iff (!resetn_i)
    rd_fall && stk_hit && stack_q[0] == `OFS_HIST_SECOND_WORD);
endmodule : addr_history_stack

// *** testbench/host_model.sv ***
`timescale 1ns/1ps
// Host side of the muxed bus; levels held 4+ clocks for the synchroniser
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic oe_n_i,
  output logic ale_o,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] ad_o
);
  initial begin
    ale_o = 1'b0;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ad_o = 8'hC3;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hold
  task automatic latch(input logic [7:0] a);
    ale_o = 1'b1;
    ad_o = a;
    hold(4);
    ale_o = 1'b0;
    hold(5);
    ad_o = ~a; // Released lines must not keep the old value
    hold(1);
  endtask : latch
  task automatic write(input logic [7:0] d);
    cs_n_o = 1'b0;
    wr_n_o = 1'b0;
    ad_o = d;
    hold(4);
    wr_n_o = 1'b1;
    hold(4);
    cs_n_o = 1'b1;
    ad_o = ~d;
    hold(4);
  endtask : write
  task automatic read(output logic [7:0] d, output logic oe_n);
    cs_n_o = 1'b0;
    rd_n_o = 1'b0;
    hold(6);
    d = rdata_i;
    oe_n = oe_n_i;
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
    hold(6);
  endtask : read
endmodule : host_model

// *** testbench/addr_history_stack_tb_top.sv ***
`timescale 1ns/1ps
module addr_history_stack_tb_top;
  typedef struct {logic [7:0] p, x, sel, exp;} row_t;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  wire logic ale, cs_n, rd_n, wr_n, oe_n, bank;
  wire logic [7:0] h_ad, u_ad, ad_w;
  logic g_oe;
  logic [7:0] got;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  row_t rows [4] = '{'{8'h21, 8'h35, 8'h4E, 8'h35},
    '{8'h07, 8'h7F, 8'h4F, 8'h07}, '{8'h00, 8'hFF, 8'h4E, 8'hFF},
    '{8'h4E, 8'h4F, 8'h4F, 8'h4E}};
  always #25 clk_i = ~clk_i;
  assign ad_w = oe_n ? h_ad : u_ad;
  addr_history_stack uut (.clk_i(clk_i), .resetn_i(resetn_i),
    .ale_i(ale), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .ad_i(ad_w), .ad_o(u_ad), .ad_oe_n_o(oe_n),
    .bank_select_bit_o(bank));
  host_model host (.clk_i(clk_i), .rdata_i(u_ad), .oe_n_i(oe_n),
    .ale_o(ale), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .ad_o(h_ad));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic results();
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // Ceiling is about nine times the expected run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    host.hold(20);
    chk(u_ad, 8'h00);
    chk({7'h00, oe_n}, 8'h01);
    chk({7'h00, bank}, 8'h00);
    resetn_i = 1'b1;
    host.hold(3);
    foreach (rows[i]) begin
      host.latch(rows[i].p);
      host.latch(rows[i].x);
      host.latch(8'h0A);
      host.write(8'h10);
      host.latch(rows[i].sel);
      host.read(got, g_oe);
      chk({7'h00, g_oe}, 8'h00);
      chk(got, rows[i].exp);
    end
    chk({7'h00, bank}, 8'h01);
    host.latch(8'h4E);
    host.write(8'hA5);
    host.latch(8'h11);
    host.latch(8'h4E);
    host.read(got, g_oe);
    chk(got, 8'h4E);
    host.latch(8'h0A);
    host.write(8'h00);
    chk({7'h00, bank}, 8'h00);
    host.latch(8'h4E);
    host.read(got, g_oe);
    chk({7'h00, g_oe}, 8'h01);
    host.latch(8'h0A);
    host.write(8'h10);
    chk({7'h00, bank}, 8'h01);
    resetn_i = 1'b0;
    host.hold(2);
    chk({7'h00, bank}, 8'h00);
    chk({7'h00, oe_n}, 8'h01);
    chk(u_ad, 8'h00);
    resetn_i = 1'b1;
    host.hold(3);
    host.latch(8'h0A);
    host.write(8'h10);
    host.latch(8'h4E);
    host.read(got, g_oe);
    chk({7'h00, g_oe}, 8'h00);
    chk(got, 8'h00);
    results();
  end
endmodule : addr_history_stack_tb_top
